//--- verilog/dmaevf_pkg.sv
// Constants, field layout and helper functions for the DMA channel event flags.
// Assumes a 32-bit register bus with word-only access and eight channels.
package dmaevf_pkg;

    localparam int NUM_CH = 8;
    localparam int FLAGS_PER_CH = 4;
    localparam int WORD_W = 32;

    // Register offsets inside the DMA register window
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] CLEAR_OFS = 8'h04;

    // Field positions inside each channel nibble
    localparam int ANY_POS = 0;
    localparam int DONE_POS = 1;
    localparam int HALF_POS = 2;
    localparam int FAULT_POS = 3;

    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum {
        DMAEVF_BUS_OK,
        DMAEVF_BUS_ERR1,
        DMAEVF_BUS_ERR2
    } dmaevf_bus_e;

    // Places bit c of a per-channel vector at bit 4*c+pos of a status word
    function automatic logic [WORD_W-1:0] dmaevf_spread(input logic [NUM_CH-1:0] v, input int pos);
        logic [WORD_W-1:0] w;
        w = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            w[c*FLAGS_PER_CH+pos] = v[c];
        end
        return w;
    endfunction

    // Picks one field of every channel out of a status or clear word
    function automatic logic [NUM_CH-1:0] dmaevf_field(input logic [WORD_W-1:0] w, input int pos);
        logic [NUM_CH-1:0] v;
        v = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            v[c] = w[c*FLAGS_PER_CH+pos];
        end
        return v;
    endfunction

endpackage

//--- verilog/dmaevf_chan_if.sv
// Event and clear lines of one channel between the bus logic and its flag store.
// Assumes set and clear strobes are one-cycle pulses on the bus clock.
`timescale 1ns/10ps
interface dmaevf_chan_if;
    logic set_done;
    logic set_half;
    logic set_fault;
    logic [3:0] clr;
    logic [3:0] flags;

    modport core (input set_done, input set_half, input set_fault, input clr, output flags);
    modport ctrl (output set_done, output set_half, output set_fault, output clr, input flags);
endinterface

//--- verilog/dmaevf_chan_flags.sv
// Four sticky event flags of one DMA channel.
// Assumes the clear nibble is already masked to a single bus write cycle.
`timescale 1ns/10ps
module dmaevf_chan_flags (
    input wire logic clk_i,
    input wire logic rst_i,
    dmaevf_chan_if.core ch
);

    logic any_event;
    logic clr_all;

    assign any_event = ch.set_done | ch.set_half | ch.set_fault;
    assign clr_all = ch.clr[dmaevf_pkg::ANY_POS];

    // Set term is ORed last so a colliding event survives the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch.flags <= dmaevf_pkg::FLAGS_RESET;
        end else begin
            ch.flags[dmaevf_pkg::ANY_POS] <= (ch.flags[dmaevf_pkg::ANY_POS] & ~clr_all) | any_event;
            ch.flags[dmaevf_pkg::DONE_POS] <= (ch.flags[dmaevf_pkg::DONE_POS]
                & ~(ch.clr[dmaevf_pkg::DONE_POS] | clr_all)) | ch.set_done;
            ch.flags[dmaevf_pkg::HALF_POS] <= (ch.flags[dmaevf_pkg::HALF_POS]
                & ~(ch.clr[dmaevf_pkg::HALF_POS] | clr_all)) | ch.set_half;
            ch.flags[dmaevf_pkg::FAULT_POS] <= (ch.flags[dmaevf_pkg::FAULT_POS]
                & ~(ch.clr[dmaevf_pkg::FAULT_POS] | clr_all)) | ch.set_fault;
        end
    end

endmodule // dmaevf_chan_flags

//--- verilog/dmaevf_top.sv
// Event flag bank of an eight-channel DMA: read-only status word, write-only clear word.
// Assumes an AHB-Lite style word-only slave port and one-cycle event pulses from the channel engines.
//
// Behaviour
// - Status word gives channel c bits 4c..4c+3: any, done, halfway, fault.
// - A finished transfer sets that channel's done flag.
// - Reaching the half-transfer point sets that channel's halfway flag.
// - A transfer error sets that channel's fault flag.
// - Any done, halfway or fault event also sets the channel's any-event flag.
// - Only hardware events set flags; status word writes change nothing.
// - A set flag stays set until a one is written to its clear bit or to its channel's clear-all bit.
// - All flags reset to zero; zero means no event since reset or clear.
// - Clear word decodes at offset 0x04, status word at offset 0x00.
// - Writing the channel clear-all bit clears all four flags of that channel.
// - Clear word is write-only; zero bits leave flags unchanged.
// - A fault stops the channel; its interrupt needs the fault enable.
// - Halfway, done and fault events reach the interrupt through separate enables.
`timescale 1ns/10ps
module dmaevf_top (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic HSEL_I,
    input wire logic [7:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic [7:0] CH_DONE_I,
    input wire logic [7:0] CH_HALF_I,
    input wire logic [7:0] CH_FAULT_I,
    input wire logic [7:0] DONE_IRQ_ENABLE_I,
    input wire logic [7:0] HALFWAY_IRQ_ENABLE_I,
    input wire logic [7:0] FAULT_IRQ_ENABLE_I,
    output logic [7:0] CH_STOP_O,
    output logic [7:0] CH_IRQ_O
);

    localparam int NCH = dmaevf_pkg::NUM_CH;
    localparam int FPC = dmaevf_pkg::FLAGS_PER_CH;

    dmaevf_pkg::dmaevf_bus_e bus_state_reg;
    logic addr_valid;
    logic size_ok;
    logic wr_clear_reg;
    logic [31:0] rdata_reg;
    logic [31:0] status_word;
    logic [31:0] clr_word;
    logic [7:0] stop_reg;
    logic [7:0] irq_reg;
    logic [7:0] irq_next;

    dmaevf_chan_if chan_if[NCH]();

    // Address phase: HSEL with HTRANS NONSEQ or SEQ while the bus is ready
    assign addr_valid = HSEL_I & HREADY_I & HTRANS_I[1];
    assign size_ok = (HSIZE_I == dmaevf_pkg::HSIZE_WORD);

    // Bytes and halfwords answer with a two-cycle error
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            bus_state_reg <= dmaevf_pkg::DMAEVF_BUS_OK;
        end else begin
            unique case (bus_state_reg)
                dmaevf_pkg::DMAEVF_BUS_ERR1: begin
                    bus_state_reg <= dmaevf_pkg::DMAEVF_BUS_ERR2;
                end
                dmaevf_pkg::DMAEVF_BUS_OK, dmaevf_pkg::DMAEVF_BUS_ERR2: begin
                    if (addr_valid && !size_ok) begin
                        bus_state_reg <= dmaevf_pkg::DMAEVF_BUS_ERR1;
                    end else begin
                        bus_state_reg <= dmaevf_pkg::DMAEVF_BUS_OK;
                    end
                end
            endcase
        end
    end

    assign HREADYOUT_O = (bus_state_reg != dmaevf_pkg::DMAEVF_BUS_ERR1);
    assign HRESP_O = (bus_state_reg != dmaevf_pkg::DMAEVF_BUS_OK);

    // Only the clear word accepts writes; the status word ignores them
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            wr_clear_reg <= 1'b0;
        end else begin
            wr_clear_reg <= addr_valid & size_ok & HWRITE_I & (HADDR_I == dmaevf_pkg::CLEAR_OFS);
        end
    end

    // Write data arrives one cycle after the address, so the clear acts then
    assign clr_word = wr_clear_reg ? HWDATA_I : '0;

    // Status is sampled at the address phase; the clear word reads as zero
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            rdata_reg <= dmaevf_pkg::RDATA_RESET;
        end else if (addr_valid && size_ok && !HWRITE_I) begin
            rdata_reg <= (HADDR_I == dmaevf_pkg::STATUS_OFS) ? status_word : '0;
        end
    end

    assign HRDATA_O = rdata_reg;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign chan_if[g].set_done = CH_DONE_I[g];
            assign chan_if[g].set_half = CH_HALF_I[g];
            assign chan_if[g].set_fault = CH_FAULT_I[g];
            assign chan_if[g].clr = clr_word[g*FPC +: FPC];
            assign status_word[g*FPC +: FPC] = chan_if[g].flags;

            dmaevf_chan_flags u_flags (
                .clk_i(REF_CLK_I),
                .rst_i(RST_I),
                .ch(chan_if[g].core)
            );
        end
    endgenerate

    // Interrupts follow the sticky flags, so they hold until software clears
    assign irq_next = (dmaevf_pkg::dmaevf_field(status_word, dmaevf_pkg::DONE_POS) & DONE_IRQ_ENABLE_I)
        | (dmaevf_pkg::dmaevf_field(status_word, dmaevf_pkg::HALF_POS) & HALFWAY_IRQ_ENABLE_I)
        | (dmaevf_pkg::dmaevf_field(status_word, dmaevf_pkg::FAULT_POS) & FAULT_IRQ_ENABLE_I);

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // One-cycle pulse telling the channel config to drop its enable bit
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            stop_reg <= '0;
        end else begin
            stop_reg <= CH_FAULT_I;
        end
    end

    assign CH_IRQ_O = irq_reg;
    assign CH_STOP_O = stop_reg;

    // Checks
    logic [31:0] set_all;
    logic [31:0] clr_eff;
    logic [31:0] en_mask;
    logic [31:0] irq_src;

    assign set_all = dmaevf_pkg::dmaevf_spread(CH_DONE_I, dmaevf_pkg::DONE_POS)
        | dmaevf_pkg::dmaevf_spread(CH_HALF_I, dmaevf_pkg::HALF_POS)
        | dmaevf_pkg::dmaevf_spread(CH_FAULT_I, dmaevf_pkg::FAULT_POS)
        | dmaevf_pkg::dmaevf_spread(CH_DONE_I | CH_HALF_I | CH_FAULT_I, dmaevf_pkg::ANY_POS);
    assign clr_eff = clr_word
        | dmaevf_pkg::dmaevf_spread(dmaevf_pkg::dmaevf_field(clr_word, dmaevf_pkg::ANY_POS), dmaevf_pkg::DONE_POS)
        | dmaevf_pkg::dmaevf_spread(dmaevf_pkg::dmaevf_field(clr_word, dmaevf_pkg::ANY_POS), dmaevf_pkg::HALF_POS)
        | dmaevf_pkg::dmaevf_spread(dmaevf_pkg::dmaevf_field(clr_word, dmaevf_pkg::ANY_POS), dmaevf_pkg::FAULT_POS);

    // Enables laid over the status layout, so the check does not reuse the interrupt path
    assign en_mask = dmaevf_pkg::dmaevf_spread(DONE_IRQ_ENABLE_I, dmaevf_pkg::DONE_POS)
        | dmaevf_pkg::dmaevf_spread(HALFWAY_IRQ_ENABLE_I, dmaevf_pkg::HALF_POS)
        | dmaevf_pkg::dmaevf_spread(FAULT_IRQ_ENABLE_I, dmaevf_pkg::FAULT_POS);
    assign irq_src = status_word & en_mask;

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);

    done_set_a: assert property (1'b1 |=>
        (status_word[17] == 1'b1) || !$past(CH_DONE_I[4]))
        else $error("done event did not set done flag");

    half_set_a: assert property (CH_HALF_I[5] |=> status_word[22])
        else $error("halfway event did not set halfway flag");

    fault_set_a: assert property (CH_FAULT_I[6] |=> status_word[27] && status_word[24])
        else $error("fault event did not set fault and any flags");

    any_set_a: assert property (1'b1 |=>
        (status_word & $past(set_all)) == $past(set_all))
        else $error("event flag missing one cycle after its event");

    no_spurious_a: assert property (1'b1 |=>
        (status_word & ~$past(status_word) & ~$past(set_all)) == '0)
        else $error("flag rose without a hardware event");

    flag_hold_a: assert property (1'b1 |=>
        (($past(status_word) & ~$past(clr_eff)) & ~status_word) == '0)
        else $error("flag dropped without a clear");

    clear_act_a: assert property (1'b1 |=>
        (status_word & $past(clr_eff) & ~$past(set_all)) == '0)
        else $error("clear did not drop flag");

    set_wins_a: assert property ((CH_DONE_I[3] && clr_word[12]) |=> status_word[12] && status_word[13])
        else $error("clear beat a simultaneous event");

    reset_zero_a: assert property (@(posedge REF_CLK_I) disable iff (1'b0) RST_I |=> status_word == '0)
        else $error("flags not zero after reset");

    read_data_a: assert property ((addr_valid && size_ok && !HWRITE_I
        && HADDR_I == dmaevf_pkg::STATUS_OFS) |=> HRDATA_O == $past(status_word))
        else $error("status read returned wrong data");

    err_resp_a: assert property ((addr_valid && !size_ok && HREADYOUT_O)
        |=> (!HREADYOUT_O && HRESP_O) ##1 (HREADYOUT_O && HRESP_O))
        else $error("narrow access lacks two-cycle error");

    fault_stop_a: assert property (CH_FAULT_I[6] |=> CH_STOP_O[6] ##1
        (CH_IRQ_O[6] || !$past(FAULT_IRQ_ENABLE_I[6])))
        else $error("fault did not stop channel or gate interrupt");

    irq_gate_a: assert property (1'b1 |=> CH_IRQ_O == $past(
        dmaevf_pkg::dmaevf_field(irq_src, dmaevf_pkg::DONE_POS)
        | dmaevf_pkg::dmaevf_field(irq_src, dmaevf_pkg::HALF_POS)
        | dmaevf_pkg::dmaevf_field(irq_src, dmaevf_pkg::FAULT_POS)))
        else $error("interrupt output not gated by enables");

    done_cov_c: cover property (CH_DONE_I[4] ##1 status_word[17]);
    clear_cov_c: cover property (status_word[4] ##1 clr_word[4] ##1 !status_word[4]);
    err_cov_c: cover property (addr_valid && !size_ok ##2 HRESP_O);
    clash_cov_c: cover property (CH_DONE_I[3] && clr_word[12]);
    masked_cov_c: cover property (CH_FAULT_I[1] && !FAULT_IRQ_ENABLE_I[1] ##2 !CH_IRQ_O[1]);

endmodule // dmaevf_top

//--- testbench/dmaevf_tb.sv
// Self-checking bench for the DMA event flag bank: status reads, clear writes, event pulses.
// Assumes the bank is the only slave on the bus, so bus ready is taken from its own ready output.
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] ev_done = 8'h00;
    logic [7:0] ev_half = 8'h00;
    logic [7:0] ev_fault = 8'h00;
    logic [7:0] den = 8'h00;
    logic [7:0] hen = 8'h00;
    logic [7:0] fen = 8'h00;
    logic [7:0] stop;
    logic [7:0] irq;
    logic [31:0] exp_st = 32'h0000_0000;
    logic [31:0] rd;
    logic rs;
    int n_fail = 0;
    int checks = 0;

    // Single slave: its ready closes every data phase
    assign hready = hreadyout;

    dmaevf_top dut (.REF_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .CH_DONE_I(ev_done), .CH_HALF_I(ev_half),
        .CH_FAULT_I(ev_fault), .DONE_IRQ_ENABLE_I(den), .HALFWAY_IRQ_ENABLE_I(hen),
        .FAULT_IRQ_ENABLE_I(fen), .CH_STOP_O(stop), .CH_IRQ_O(irq));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One transfer; dev pulses done events during the data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] s,
                       input logic [7:0] dev);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= s;
        @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        ev_done <= dev;
        for (int i = 0; i < 5; i++) begin
            #1;
            if (hreadyout === 1'b1) begin
                rd = hrdata;
                rs = hresp;
                break;
            end
            if (i == 4) begin
                n_fail++;
                results();
            end
            @(posedge clk);
        end
        @(posedge clk);
        ev_done <= 8'h00;
        #1;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, 3'h2, 8'h00);
        check("rdata", rd, e);
        check("resp", {31'h0, rs}, 32'h0000_0000);
    endtask

    task automatic set_ev(input logic [7:0] m, input int pos);
        for (int c = 0; c < 8; c++) begin
            if (m[c]) begin
                exp_st[4*c+pos] = 1'b1;
                exp_st[4*c] = 1'b1;
            end
        end
    endtask

    task automatic clr_exp(input logic [31:0] d);
        for (int c = 0; c < 8; c++) begin
            if (d[4*c]) begin
                d[4*c+:4] = 4'hf;
            end
        end
        exp_st = exp_st & ~d;
    endtask

    task automatic pulse(input logic [7:0] d, input logic [7:0] h, input logic [7:0] f);
        @(posedge clk);
        ev_done <= d;
        ev_half <= h;
        ev_fault <= f;
        @(posedge clk);
        ev_done <= 8'h00;
        ev_half <= 8'h00;
        ev_fault <= 8'h00;
        #1;
        check("stop", {24'h0, stop}, {24'h0, f});
        set_ev(d, 1);
        set_ev(h, 2);
        set_ev(f, 3);
    endtask

    function automatic logic [31:0] irq_of(input logic [31:0] st);
        logic [31:0] r;
        r = '0;
        for (int c = 0; c < 8; c++) begin
            r[c] = (st[4*c+1] & den[c]) | (st[4*c+2] & hen[c]) | (st[4*c+3] & fen[c]);
        end
        return r;
    endfunction

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        exp_st = 32'h0000_0000;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk(8'h00, 32'h0000_0000);
        rdchk(8'h04, 32'h0000_0000);
        check("irq", {24'h0, irq}, 32'h0000_0000);
        @(posedge clk);
        den <= 8'h10;
        fen <= 8'hff;
        pulse(8'h10, 8'h00, 8'h00);
        pulse(8'h00, 8'h20, 8'h00);
        pulse(8'h00, 8'h00, 8'h40);
        pulse(8'h80, 8'h80, 8'h80);
        pulse(8'h01, 8'h02, 8'h04);
        rdchk(8'h00, exp_st);
        check("irq", {24'h0, irq}, irq_of(exp_st));
        @(posedge clk);
        hen <= 8'hff;
        repeat (2) @(posedge clk);
        #1;
        check("irq", {24'h0, irq}, irq_of(exp_st));
        bus(1'b1, 8'h00, 32'hffff_ffff, 3'h2, 8'h00);
        rdchk(8'h00, exp_st);
        bus(1'b1, 8'h08, 32'hffff_ffff, 3'h2, 8'h00);
        check("resp", {31'h0, rs}, 32'h0000_0000);
        rdchk(8'h08, 32'h0000_0000);
        rdchk(8'h00, exp_st);
        bus(1'b1, 8'h04, 32'h0002_0000, 3'h2, 8'h00);
        clr_exp(32'h0002_0000);
        rdchk(8'h00, exp_st);
        bus(1'b1, 8'h04, 32'hffff_ffff, 3'h0, 8'h00);
        check("resp", {31'h0, rs}, 32'h0000_0001);
        rdchk(8'h00, exp_st);
        bus(1'b1, 8'h04, 32'h0100_0000, 3'h2, 8'h00);
        clr_exp(32'h0100_0000);
        rdchk(8'h00, exp_st);
        pulse(8'h08, 8'h00, 8'h00);
        bus(1'b1, 8'h04, 32'h0000_3000, 3'h2, 8'h08);
        clr_exp(32'h0000_3000);
        set_ev(8'h08, 1);
        rdchk(8'h00, exp_st);
        check("irq", {24'h0, irq}, irq_of(exp_st));
        bus(1'b1, 8'h04, 32'hffff_ffff, 3'h2, 8'h00);
        clr_exp(32'hffff_ffff);
        rdchk(8'h00, exp_st);
        @(posedge clk);
        fen <= 8'h00;
        pulse(8'h00, 8'h00, 8'h02);
        @(posedge clk);
        #1;
        check("irq", {24'h0, irq}, irq_of(exp_st));
        do_reset();
        rdchk(8'h00, 32'h0000_0000);
        check("irq", {24'h0, irq}, 32'h0000_0000);
        check("stop", {24'h0, stop}, 32'h0000_0000);
        results();
    end
endmodule // testbench
